/* File: shared/dmacc_pkg.sv */
// Constants, types and helpers shared by the DMA channel count/config block
package dmacc_pkg;
    localparam int NUM_CH     = 8;
    localparam int CNT_W      = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int LVL_W      = 5;
    localparam int BURST_W    = 9;
    localparam int ADDR_W     = 12;
    localparam int CTRL_HI_W  = 20;
    localparam int CFG_RW_W   = 17;
    localparam int RSVD_W     = 13;
    localparam int REGION_LO  = 8;
    localparam int CH_LO      = 5;
    localparam int CH_W       = 3;
    localparam int OFS_W      = 5;
    localparam int SB_LO      = 12;
    localparam int SB_W       = 3;
    localparam int SB_POS     = SB_LO - CNT_W;
    localparam int ENABLE_BIT = 0;
    localparam int FLOW_PERIPH_BIT = 13;
    localparam int ACTIVE_BIT = 17;
    localparam int HALT_BIT   = 18;
    localparam int RSVD_LO    = 19;
    localparam int HTRANS_ACTIVE_BIT = 1;

    localparam logic [3:0]           REGION_ID  = 4'h1;
    localparam logic [OFS_W-1:0]     CTRL_OFS   = 5'h0C;
    localparam logic [OFS_W-1:0]     CFG_OFS    = 5'h10;
    localparam logic [2:0]           HSIZE_WORD = 3'h2;
    localparam logic                 HRESP_OKAY = 1'h0;
    localparam logic [RSVD_W-1:0]    RSVD_ZERO  = 13'h0000;
    localparam logic [LVL_W-1:0]     LVL_ONE    = 5'h01;
    localparam logic [LVL_W-1:0]     LVL_FULL   = 5'h10;
    localparam logic [LVL_W-1:0]     LVL_EMPTY  = 5'h00;
    localparam logic [CNT_W-1:0]     CNT_ONE    = 12'h001;
    localparam logic [CNT_W-1:0]     CNT_ZERO   = 12'h000;
    localparam logic [BURST_W-1:0]   BURST_ONE  = 9'h001;
    localparam logic [BURST_W-1:0]   BURST_ZERO = 9'h000;
    localparam logic [SB_W:0]        SB_SHIFT_ADJ = 4'h1;

    typedef enum logic [1:0] {DMACC_IDLE, DMACC_RUN, DMACC_WAIT} dmacc_state_t;

    typedef struct packed {
        logic [NUM_CH-1:0][CTRL_HI_W-1:0] ctrl_hi;
        logic [NUM_CH-1:0][CNT_W-1:0]     count;
        logic [NUM_CH-1:0][CFG_RW_W-1:0]  cfg;
        logic [NUM_CH-1:0]                halt;
        dmacc_state_t [NUM_CH-1:0]        st;
        logic [NUM_CH-1:0][LVL_W-1:0]     level;
        logic [NUM_CH-1:0][BURST_W-1:0]   burst;
        logic [NUM_CH-1:0][CNT_W-1:0]     fetched;
        logic [NUM_CH-1:0][CNT_W-1:0]     done;
        logic [NUM_CH-1:0]                last_seen;
    } dmacc_regs_t;

    typedef struct packed {
        logic              wr_pend;
        logic [ADDR_W-1:0] wr_addr;
        logic [31:0]       rdata;
    } dmacc_slv_t;

    localparam dmacc_regs_t REGS_RST = '0;
    localparam dmacc_slv_t  SLV_RST  = '0;

    // Code 0 is a single transfer, code n above 0 is 2^(n+1) transfers
    function automatic logic [BURST_W-1:0] dmacc_burst_len(input logic [SB_W-1:0] code);
        logic [SB_W:0] sh;
        sh = {1'b0, code} + SB_SHIFT_ADJ;
        return (code == 3'h0) ? BURST_ONE : (BURST_ONE << sh);
    endfunction
endpackage

/* File: shared/dmacc_bus_if.sv */
// Register access path between the AHB-Lite front end and the channel registers
`timescale 1ns/10ps
interface dmacc_bus_if
    import dmacc_pkg::*;
    ();
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] rd_addr;
    logic [31:0]       wdata;
    logic [31:0]       rdata;

    modport master (output wr_en, output wr_addr, output rd_addr, output wdata, input rdata);
    modport regs   (input wr_en, input wr_addr, input rd_addr, input wdata, output rdata);
endinterface

/* File: rtl/dmacc_ahb_slave.sv */
// AHB-Lite slave front end with zero wait states
`timescale 1ns/10ps
module dmacc_ahb_slave
    import dmacc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    dmacc_bus_if.master      bus
);
    dmacc_slv_t s_q;
    dmacc_slv_t s_d;
    logic       take;

    // Only whole-word transfers are accepted; others are ignored
    assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready && (hsize == HSIZE_WORD);

    always_comb
    begin
        s_d = s_q;
        s_d.wr_pend = take && hwrite;
        if (take && hwrite)
        begin
            s_d.wr_addr = haddr[ADDR_W-1:0];
        end
        if (take && !hwrite)
        begin
            s_d.rdata = bus.rdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            s_q <= SLV_RST;
        else if (ce)
            s_q <= s_d;
    end

    assign bus.wr_en   = s_q.wr_pend;
    assign bus.wr_addr = s_q.wr_addr;
    assign bus.rd_addr = haddr[ADDR_W-1:0];
    assign bus.wdata   = hwdata;
    assign hrdata      = s_q.rdata;
    assign hreadyout   = 1'b1;
    assign hresp       = HRESP_OKAY;
endmodule

/* File: rtl/dmacc_top.sv */
// Eight DMA channels: transfer count, halt, active flag and enable handling
//
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module dmacc_top
    import dmacc_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              SRST,
    input  wire logic              CE,
    input  wire logic              HSEL,
    input  wire logic [31:0]       HADDR,
    input  wire logic [1:0]        HTRANS,
    input  wire logic              HWRITE,
    input  wire logic [2:0]        HSIZE,
    input  wire logic [31:0]       HWDATA,
    input  wire logic              HREADY,
    output logic      [31:0]       HRDATA,
    output logic                   HREADYOUT,
    output logic                   HRESP,
    input  wire logic [NUM_CH-1:0] SRC_REQ,
    output logic      [NUM_CH-1:0] SRC_XFER,
    input  wire logic [NUM_CH-1:0] DST_RDY,
    output logic      [NUM_CH-1:0] DST_XFER,
    input  wire logic [NUM_CH-1:0] PERIPH_LAST,
    input  wire logic [NUM_CH-1:0] CH_ERR,
    input  wire logic [NUM_CH-1:0] LLI_MORE,
    input  wire logic [NUM_CH-1:0] LLI_LOAD,
    input  wire logic [31:0]       LLI_CTRL,
    output logic      [NUM_CH-1:0] LLI_REQ,
    output logic      [NUM_CH-1:0] TC
);
    dmacc_regs_t       s_q;
    dmacc_regs_t       s_d;
    logic [NUM_CH-1:0] en;
    logic [NUM_CH-1:0] dma_flow;
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] room;
    logic [NUM_CH-1:0] fetch;
    logic [NUM_CH-1:0] accept;
    logic [NUM_CH-1:0] drain;
    logic [NUM_CH-1:0] finish;
    logic [NUM_CH-1:0] active;
    logic [NUM_CH-1:0][SB_W-1:0] sb;
    logic              wr_region;
    logic              wr_ctrl;
    logic              wr_cfg;
    logic [CH_W-1:0]   wr_ch;
    logic              rd_take;
    logic              rd_region;

    dmacc_bus_if bus ();

    dmacc_ahb_slave u_slave (
        .clk       (CLK_SYS),
        .srst      (SRST),
        .ce        (CE),
        .hsel      (HSEL),
        .haddr     (HADDR),
        .htrans    (HTRANS),
        .hwrite    (HWRITE),
        .hsize     (HSIZE),
        .hwdata    (HWDATA),
        .hready    (HREADY),
        .hrdata    (HRDATA),
        .hreadyout (HREADYOUT),
        .hresp     (HRESP),
        .bus       (bus.master)
    );

    assign wr_region = bus.wr_addr[ADDR_W-1:REGION_LO] == REGION_ID;
    assign wr_ctrl   = bus.wr_en && wr_region && (bus.wr_addr[OFS_W-1:0] == CTRL_OFS);
    assign wr_cfg    = bus.wr_en && wr_region && (bus.wr_addr[OFS_W-1:0] == CFG_OFS);
    assign wr_ch     = bus.wr_addr[CH_LO +: CH_W];
    assign rd_take   = HSEL && HTRANS[HTRANS_ACTIVE_BIT] && HREADY && !HWRITE && (HSIZE == HSIZE_WORD);
    assign rd_region = HADDR[ADDR_W-1:REGION_LO] == REGION_ID;

    // Register read mux; unmapped words read as zero
    function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
        logic [CH_W-1:0] c;
        logic [31:0]     v;
        c = a[CH_LO +: CH_W];
        v = '0;
        if (a[ADDR_W-1:REGION_LO] == REGION_ID)
        begin
            if (a[OFS_W-1:0] == CTRL_OFS)
                v = {s_q.ctrl_hi[c], s_q.done[c]};
            else if (a[OFS_W-1:0] == CFG_OFS)
                v = {RSVD_ZERO, s_q.halt[c], active[c], s_q.cfg[c]};
        end
        return v;
    endfunction

    assign bus.rdata = read_word(bus.rd_addr);

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        assign en[g]       = s_q.cfg[g][ENABLE_BIT];
        assign dma_flow[g] = !s_q.cfg[g][FLOW_PERIPH_BIT];
        assign run[g]      = (s_q.st[g] == DMACC_RUN) && en[g];
        assign sb[g]       = s_q.ctrl_hi[g][SB_POS +: SB_W];
        assign room[g]     = !dma_flow[g] || (s_q.fetched[g] != s_q.count[g]);
        assign fetch[g]    = run[g] && (s_q.burst[g] != BURST_ZERO) && (s_q.level[g] < LVL_FULL) && room[g];
        assign accept[g]   = run[g] && !s_q.halt[g] && (s_q.burst[g] == BURST_ZERO) && SRC_REQ[g]
                             && room[g] && !s_q.last_seen[g];
        assign drain[g]    = run[g] && (s_q.level[g] != LVL_EMPTY) && DST_RDY[g];
        assign finish[g]   = run[g] && (s_q.level[g] == LVL_EMPTY)
                             && (dma_flow[g] ? (s_q.done[g] == s_q.count[g]) : s_q.last_seen[g]);
        assign active[g]   = s_q.level[g] != LVL_EMPTY;
        assign SRC_XFER[g] = fetch[g];
        assign DST_XFER[g] = drain[g];
        assign TC[g]       = finish[g];
        assign LLI_REQ[g]  = finish[g] && LLI_MORE[g];

        a_burst_load: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && accept[g] |=> s_q.burst[g] == dmacc_burst_len($past(sb[g])))
            else $error("burst length not loaded from code");
        a_count_cap: assert property (@(posedge CLK_SYS) disable iff (SRST)
            (s_q.st[g] == DMACC_RUN) && dma_flow[g] && (s_q.fetched[g] == s_q.count[g]) |-> !fetch[g])
            else $error("fetch beyond programmed count");
        a_done_step: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && drain[g] |=> s_q.done[g] == $past(s_q.done[g]) + CNT_ONE)
            else $error("completed count did not advance");
        a_count_read: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && rd_take && rd_region && (HADDR[CH_LO +: CH_W] == CH_W'(g)) && (HADDR[OFS_W-1:0] == CTRL_OFS)
            |=> HRDATA[CNT_W-1:0] == $past(s_q.done[g]))
            else $error("count readback differs from completed count");
        a_periph_flow: assert property (@(posedge CLK_SYS) disable iff (SRST)
            run[g] && !dma_flow[g] && (s_q.burst[g] != BURST_ZERO) && (s_q.level[g] < LVL_FULL) |-> fetch[g])
            else $error("peripheral flow fetch blocked");
        a_cfg_write: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && wr_cfg && (wr_ch == CH_W'(g)) && !CH_ERR[g] && !finish[g]
            |=> s_q.cfg[g] == $past(bus.wdata[CFG_RW_W-1:0]))
            else $error("config write not stored");
        a_cfg_keep: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && LLI_LOAD[g] && !bus.wr_en && !CH_ERR[g] && !finish[g] |=> $stable(s_q.cfg[g]))
            else $error("config changed on list item reload");
        a_halt_block: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && s_q.halt[g] && (s_q.burst[g] == BURST_ZERO) |=> s_q.burst[g] == BURST_ZERO)
            else $error("burst started while halted");
        a_halt_drain: assert property (@(posedge CLK_SYS) disable iff (SRST)
            s_q.halt[g] && run[g] && (s_q.level[g] != LVL_EMPTY) && DST_RDY[g] |-> DST_XFER[g])
            else $error("halted channel stopped draining");
        a_active_low: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && rd_take && rd_region && (HADDR[CH_LO +: CH_W] == CH_W'(g)) && (HADDR[OFS_W-1:0] == CFG_OFS)
            && (s_q.level[g] == LVL_EMPTY) |=> !HRDATA[ACTIVE_BIT])
            else $error("active read 1 with empty FIFO");
        a_active_high: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && rd_take && rd_region && (HADDR[CH_LO +: CH_W] == CH_W'(g)) && (HADDR[OFS_W-1:0] == CFG_OFS)
            && (s_q.level[g] != LVL_EMPTY) |=> HRDATA[ACTIVE_BIT])
            else $error("active read 0 with data in FIFO");
        a_flush_off: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && (s_q.st[g] == DMACC_RUN) && !en[g] |=> (s_q.level[g] == LVL_EMPTY) && (s_q.st[g] == DMACC_IDLE))
            else $error("disabled channel kept FIFO data");
        a_auto_clear: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && ((finish[g] && !LLI_MORE[g]) || CH_ERR[g]) |=> !s_q.cfg[g][ENABLE_BIT])
            else $error("enable not cleared at end or error");
        a_count_end: assert property (@(posedge CLK_SYS) disable iff (SRST)
            CE && run[g] && dma_flow[g] && (s_q.done[g] == s_q.count[g]) && (s_q.level[g] == LVL_EMPTY)
            |=> s_q.st[g] != DMACC_RUN)
            else $error("transfer did not end at count");
    end

    a_rsvd_zero: assert property (@(posedge CLK_SYS) disable iff (SRST)
        CE && rd_take && rd_region && (HADDR[OFS_W-1:0] == CFG_OFS) |=> HRDATA[31:RSVD_LO] == RSVD_ZERO)
        else $error("reserved config bits not masked");

    always_comb
    begin
        s_d = s_q;
        for (int i = 0; i < NUM_CH; i++)
        begin
            case (s_q.st[i])
                DMACC_IDLE:
                begin
                    if (en[i])
                    begin
                        s_d.st[i]        = DMACC_RUN;
                        s_d.level[i]     = LVL_EMPTY;
                        s_d.burst[i]     = BURST_ZERO;
                        s_d.fetched[i]   = CNT_ZERO;
                        s_d.done[i]      = CNT_ZERO;
                        s_d.last_seen[i] = 1'b0;
                    end
                end
                DMACC_RUN:
                begin
                    if (!en[i])
                    begin
                        s_d.st[i]    = DMACC_IDLE;
                        s_d.level[i] = LVL_EMPTY;
                        s_d.burst[i] = BURST_ZERO;
                    end
                    else
                    begin
                        if (fetch[i] && !drain[i])
                            s_d.level[i] = s_q.level[i] + LVL_ONE;
                        else if (drain[i] && !fetch[i])
                            s_d.level[i] = s_q.level[i] - LVL_ONE;
                        if (accept[i])
                            s_d.burst[i] = dmacc_burst_len(sb[i]);
                        else if (fetch[i])
                            s_d.burst[i] = (dma_flow[i] && (s_q.fetched[i] + CNT_ONE == s_q.count[i]))
                                           ? BURST_ZERO : s_q.burst[i] - BURST_ONE;
                        if (fetch[i])
                            s_d.fetched[i] = s_q.fetched[i] + CNT_ONE;
                        if (drain[i])
                            s_d.done[i] = s_q.done[i] + CNT_ONE;
                        if (PERIPH_LAST[i] && !dma_flow[i])
                            s_d.last_seen[i] = 1'b1;
                        if (finish[i])
                            s_d.st[i] = LLI_MORE[i] ? DMACC_WAIT : DMACC_IDLE;
                    end
                end
                DMACC_WAIT:
                begin
                    if (!en[i])
                        s_d.st[i] = DMACC_IDLE;
                    else if (LLI_LOAD[i])
                    begin
                        s_d.st[i]        = DMACC_RUN;
                        s_d.burst[i]     = BURST_ZERO;
                        s_d.fetched[i]   = CNT_ZERO;
                        s_d.done[i]      = CNT_ZERO;
                        s_d.last_seen[i] = 1'b0;
                    end
                end
                default:
                    s_d.st[i] = DMACC_IDLE;
            endcase

            if (wr_ctrl && (wr_ch == CH_W'(i)))
            begin
                s_d.ctrl_hi[i] = bus.wdata[31:CNT_W];
                s_d.count[i]   = bus.wdata[CNT_W-1:0];
            end
            if (wr_cfg && (wr_ch == CH_W'(i)))
            begin
                s_d.cfg[i]  = bus.wdata[CFG_RW_W-1:0];
                s_d.halt[i] = bus.wdata[HALT_BIT];
            end
            if (LLI_LOAD[i] && (s_q.st[i] == DMACC_WAIT))
            begin
                s_d.ctrl_hi[i] = LLI_CTRL[31:CNT_W];
                s_d.count[i]   = LLI_CTRL[CNT_W-1:0];
            end
            if ((finish[i] && !LLI_MORE[i]) || CH_ERR[i])
                s_d.cfg[i][ENABLE_BIT] = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (SRST)
            s_q <= REGS_RST;
        else if (CE)
            s_q <= s_d;
    end
endmodule

/* File: dv/dmacc_far_model.sv */
// Far-side model: requesting peripherals, destinations and list-item source
`timescale 1ns/10ps
module dmacc_far_model
    import dmacc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic [NUM_CH-1:0] src_on,
    input  wire logic [NUM_CH-1:0] dst_on,
    input  wire logic [31:0]       next_ctrl,
    input  wire logic [NUM_CH-1:0] src_xfer,
    input  wire logic [NUM_CH-1:0] lli_req,
    output logic      [NUM_CH-1:0] src_req,
    output logic      [NUM_CH-1:0] dst_rdy,
    output logic      [NUM_CH-1:0] lli_load,
    output logic      [31:0]       lli_ctrl
);
    // Request held until its burst starts; a level on src_on keeps it up
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            src_req  <= '0;
            lli_load <= '0;
        end
        else
        begin
            src_req  <= src_on | (src_req & ~src_xfer);
            lli_load <= lli_req;
        end
    end
    assign dst_rdy  = dst_on;
    // Word valid only with the load pulse, inverted otherwise
    assign lli_ctrl = (lli_load != '0) ? next_ctrl : ~next_ctrl;
endmodule

/* File: dv/dma_channel_count_and_config_bench.sv */
// Self-checking bench for the DMA channel count and config block
`timescale 1ns/10ps
module dma_channel_count_and_config_bench
    import dmacc_pkg::*;
;
    logic              clk_sys, srst, hsel, hwrite, hready, hresp;
    logic [1:0]        htrans;
    logic [31:0]       haddr, hwdata, hrdata, next_ctrl, lli_ctrl;
    logic [NUM_CH-1:0] src_req, src_xfer, dst_rdy, dst_xfer, last, err, more, load, lreq, tc, src_on, dst_on;
    int                n_errors = 0, checks = 0, nsrc = 0, ndst = 0, ntc = 0, bs, bd, bt;

    dmacc_top dut (.CLK_SYS(clk_sys), .SRST(srst), .CE(1'b1), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(HSIZE_WORD), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .SRC_REQ(src_req), .SRC_XFER(src_xfer), .DST_RDY(dst_rdy),
        .DST_XFER(dst_xfer), .PERIPH_LAST(last), .CH_ERR(err), .LLI_MORE(more), .LLI_LOAD(load),
        .LLI_CTRL(lli_ctrl), .LLI_REQ(lreq), .TC(tc));
    dmacc_far_model fm (.clk(clk_sys), .srst(srst), .src_on(src_on), .dst_on(dst_on), .next_ctrl(next_ctrl),
        .src_xfer(src_xfer), .lli_req(lreq), .src_req(src_req), .dst_rdy(dst_rdy), .lli_load(load),
        .lli_ctrl(lli_ctrl));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        nsrc <= nsrc + $countones(src_xfer);
        ndst <= ndst + $countones(dst_xfer);
        ntc  <= ntc + $countones(tc);
    end

    function automatic logic [31:0] ctl(input int n);
        return 32'h0000010C + 32'(n) * 32'h00000020;
    endfunction
    function automatic logic [31:0] cfg(input int n);
        return 32'h00000110 + 32'(n) * 32'h00000020;
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        hsel   <= 1'b1;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h00000000, r);
    endtask
    task automatic poll(input logic [31:0] a, input logic [31:0] m, input logic [31:0] v);
        logic [31:0] r;
        r = ~v;
        for (int i = 0; i < 400 && (r & m) !== v; i++)
            rd(a, r);
        chk("poll", v, r & m); // polled value
    endtask
    task automatic mark();
        bs = nsrc;
        bd = ndst;
        bt = ntc;
    endtask
    task automatic pulse_req(input logic [NUM_CH-1:0] m);
        src_on <= m;
        @(posedge clk_sys);
        src_on <= '0;
    endtask
    task automatic wait_src(input int n);
        for (int i = 0; i < 800 && nsrc - bs < n; i++) @(posedge clk_sys);
    endtask

    task automatic t_regs();
        logic [31:0] r;
        rd(cfg(1), r);
        chk("cfg reset", 32'h00000000, r); // reset value
        wr(cfg(1), 32'h0007FFFE); // reserved bits left zero
        rd(cfg(1), r);
        chk("cfg rw", 32'h0005FFFE, r); // masked bits
        wr(ctl(1), 32'hFFFFFFFF);
        rd(ctl(1), r);
        chk("ctl rw", 32'hFFFFF000, r); // completed count
        rd(32'h00000104, r);
        chk("unmapped", 32'h00000000, r); // outside register map
        chk("hresp", 32'(HRESP_OKAY), 32'(hresp)); // okay response
        wr(cfg(1), 32'h00000000);
    endtask
    task automatic t_burst();
        int n;
        for (int c = 0; c < 8; c++)
        begin
            n = (c == 0) ? 1 : (2 << c);
            mark();
            wr(ctl(0), {17'h00000, 3'(c), 12'h12C}); // count first
            wr(cfg(0), 32'h00000001);
            pulse_req(8'h01);
            poll(ctl(0), 32'h00000FFF, 32'(n)); // burst delivered
            chk("burst len", 32'(n), 32'(nsrc - bs)); // burst code
            wr(cfg(0), 32'h00000000);
        end
    endtask
    task automatic t_flow();
        logic [31:0] r;
        mark();
        wr(ctl(0), 32'h00001005);
        src_on <= 8'h01;
        wr(cfg(0), 32'h00000001);
        poll(cfg(0), 32'h00000001, 32'h00000000); // self clear
        src_on <= 8'h00;
        chk("src total", 32'h5, 32'(nsrc - bs)); // stop at count
        chk("dst total", 32'h5, 32'(ndst - bd)); // all delivered
        chk("tc once", 32'h1, 32'(ntc - bt)); // completion pulse
        rd(ctl(0), r);
        chk("ctl done", 32'h00001005, r); // read after stop
    endtask
    task automatic t_halt();
        logic [31:0] r;
        mark();
        dst_on <= 8'h00;
        wr(ctl(2), 32'h00003028);
        wr(cfg(2), 32'h00000001);
        pulse_req(8'h04);
        wait_src(16);
        wr(cfg(2), 32'h00040001);
        src_on <= 8'h04;
        rd(cfg(2), r);
        chk("active full", 32'h00060001, r); // data held
        rd(ctl(2), r);
        chk("count stalled", 32'h00003000, r); // none delivered
        dst_on <= 8'hFF;
        poll(cfg(2), 32'h00020000, 32'h00000000); // empty flag
        chk("src halted", 32'h10, 32'(nsrc - bs)); // requests ignored
        chk("drained", 32'h10, 32'(ndst - bd)); // fifo drained
        rd(ctl(2), r);
        chk("count drained", 32'h00003010, r); // running count
        src_on <= 8'h00;
        wr(cfg(2), 32'h00000000); // enable cleared last
    endtask
    task automatic t_err();
        logic [31:0] r;
        wr(ctl(4), 32'h00000064);
        wr(cfg(4), 32'h00000001);
        err <= 8'h10;
        @(posedge clk_sys);
        err <= 8'h00;
        rd(cfg(4), r);
        chk("err clears", 32'h00000000, r); // error stop
    endtask
    task automatic t_periph();
        mark();
        wr(ctl(3), 32'h00000002);
        src_on <= 8'h08;
        wr(cfg(3), 32'h00002001);
        wait_src(6);
        last <= 8'h08;
        src_on <= 8'h00;
        @(posedge clk_sys);
        last <= 8'h00;
        poll(cfg(3), 32'h00000001, 32'h00000000); // peripheral end
        chk("count ignored", 32'h1, 32'(nsrc - bs > 2)); // beyond count
        chk("periph drain", 32'(nsrc - bs), 32'(ndst - bd)); // all delivered
        chk("periph tc", 32'h1, 32'(ntc - bt)); // single end
    endtask
    task automatic t_lli();
        logic [31:0] r;
        mark();
        more <= 8'h20;
        next_ctrl <= 32'h00000003;
        wr(ctl(5), 32'h00000002);
        src_on <= 8'h20;
        wr(cfg(5), 32'h00000401);
        for (int i = 0; i < 400 && ntc - bt < 1; i++) @(posedge clk_sys);
        more <= 8'h00;
        poll(cfg(5), 32'h00000001, 32'h00000000); // last item
        src_on <= 8'h00;
        chk("lli src", 32'h5, 32'(nsrc - bs)); // next item
        chk("lli tc", 32'h2, 32'(ntc - bt)); // two items
        rd(cfg(5), r);
        chk("cfg kept", 32'h00000400, r); // no reload
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        wrap_up();
    end
    initial
    begin
        srst = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = '0;
        last = '0;
        err = '0;
        more = '0;
        next_ctrl = '0;
        src_on = '0;
        dst_on = 8'hFF;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_regs();
        t_burst();
        t_flow();
        t_halt();
        t_err();
        t_periph();
        t_lli();
        wrap_up();
    end
endmodule
